// ---- rtl/dprpc_top.sv ----
// Port control of a two-port synchronous RAM: address counters, chip
// selects, mailbox flags and the gated data output path of both ports.
// Assumes the memory array is outside and returns read data in the cycle
// its registered read strobe is high; both ports share sys_clk.
//
// How it works
// - Strobe low loads address into counter
// - First chip select active low
// - Second chip select active high; both needed
// - Count advance low increments every edge
// - Strobe or clear low blocks increment
// - Clear zeroes only unmasked counter bits
// - Clear wins over strobe and advance
// - Mask select low targets mask register
// - Mask select high: counter operations only
// - Data driven only while output enable low
// - Top two addresses are mailboxes
// - Write to other's mailbox sets owner flag
// - Owner reading own mailbox clears flag
// - Wrap flag falls when an increment makes unmasked bits all ones
// - Master clear resets counters, masks, flags
// - Mailbox flags need an active byte lane
// - Top address right, next left mailbox
`timescale 1ns/10ps
`default_nettype none

module dprpc_top (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic master_clear_n,
  // Left port controls
  input wire logic [dprpc_pkg::ADDR_W-1:0] l_address_inputs,
  input wire logic l_address_strobe_n,
  input wire logic l_chip_select_low_active,
  input wire logic l_chip_select_high_active,
  input wire logic l_count_advance_n,
  input wire logic l_counter_clear_n,
  input wire logic l_mask_select_n,
  input wire logic l_read_write_n,
  input wire logic [dprpc_pkg::LANE_W-1:0] l_byte_lane_n,
  input wire logic l_output_enable_n,
  input wire logic [dprpc_pkg::DATA_W-1:0] l_data_in,
  // Left port outputs
  output logic [dprpc_pkg::DATA_W-1:0] l_data_out,
  output logic l_data_oe,
  output logic l_mailbox_flag_n,
  output logic l_counter_wrap_flag_n,
  // Right port controls
  input wire logic [dprpc_pkg::ADDR_W-1:0] r_address_inputs,
  input wire logic r_address_strobe_n,
  input wire logic r_chip_select_low_active,
  input wire logic r_chip_select_high_active,
  input wire logic r_count_advance_n,
  input wire logic r_counter_clear_n,
  input wire logic r_mask_select_n,
  input wire logic r_read_write_n,
  input wire logic [dprpc_pkg::LANE_W-1:0] r_byte_lane_n,
  input wire logic r_output_enable_n,
  input wire logic [dprpc_pkg::DATA_W-1:0] r_data_in,
  // Right port outputs
  output logic [dprpc_pkg::DATA_W-1:0] r_data_out,
  output logic r_data_oe,
  output logic r_mailbox_flag_n,
  output logic r_counter_wrap_flag_n,
  // Left array side
  output logic [dprpc_pkg::ADDR_W-1:0] l_array_addr_reg,
  output logic l_array_write_reg,
  output logic l_array_read_reg,
  output logic [dprpc_pkg::LANE_W-1:0] l_array_lane_en_reg,
  output logic [dprpc_pkg::DATA_W-1:0] l_array_wdata_reg,
  input wire logic [dprpc_pkg::DATA_W-1:0] l_array_rdata,
  // Right array side
  output logic [dprpc_pkg::ADDR_W-1:0] r_array_addr_reg,
  output logic r_array_write_reg,
  output logic r_array_read_reg,
  output logic [dprpc_pkg::LANE_W-1:0] r_array_lane_en_reg,
  output logic [dprpc_pkg::DATA_W-1:0] r_array_wdata_reg,
  input wire logic [dprpc_pkg::DATA_W-1:0] r_array_rdata
);

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic port_selected(input logic cs_low, input logic cs_high);
    return !cs_low && cs_high;
  endfunction : port_selected

  // Mailbox owned by a port: the right port owns the top word.
  function automatic logic [dprpc_pkg::ADDR_W-1:0] mbox_of(input int port);
    return (port == dprpc_pkg::PORT_RIGHT) ? dprpc_pkg::MBOX_RIGHT_ADDR : dprpc_pkg::MBOX_LEFT_ADDR;
  endfunction : mbox_of

  // Master clear and system reset both act at once, without the clock.
  logic reset_all_n;
  assign reset_all_n = rst_b && master_clear_n;

  // ********************************************************
  // Per-port gathering
  // ********************************************************
  logic [dprpc_pkg::ADDR_W-1:0] addr_in [2];
  logic [dprpc_pkg::ADDR_W-1:0] counter_q [2];
  logic [dprpc_pkg::ADDR_W-1:0] access_addr [2];
  logic [dprpc_pkg::LANE_W-1:0] lane_n [2];
  logic [dprpc_pkg::DATA_W-1:0] wdata [2];
  logic [dprpc_pkg::DATA_W-1:0] rdata [2];
  logic [dprpc_pkg::DATA_W-1:0] dout_reg [2];
  logic [1:0] strobe_n;
  logic [1:0] cs_low;
  logic [1:0] cs_high;
  logic [1:0] advance_n;
  logic [1:0] clear_n;
  logic [1:0] mask_sel_n;
  logic [1:0] rw_n;
  logic [1:0] oe_n;
  logic [1:0] access;
  logic [1:0] lane_any;
  logic [1:0] is_write;
  logic [1:0] is_read;
  logic [1:0] mbox_set;
  logic [1:0] mbox_clear;
  logic [1:0] mbox_flag_n;
  logic [1:0] wrap_flag_n;
  logic dvalid_reg [2];
  logic [1:0] array_rd;

  assign addr_in[0] = l_address_inputs;
  assign addr_in[1] = r_address_inputs;
  assign strobe_n = {r_address_strobe_n, l_address_strobe_n};
  assign cs_low = {r_chip_select_low_active, l_chip_select_low_active};
  assign cs_high = {r_chip_select_high_active, l_chip_select_high_active};
  assign advance_n = {r_count_advance_n, l_count_advance_n};
  assign clear_n = {r_counter_clear_n, l_counter_clear_n};
  assign mask_sel_n = {r_mask_select_n, l_mask_select_n};
  assign rw_n = {r_read_write_n, l_read_write_n};
  assign oe_n = {r_output_enable_n, l_output_enable_n};
  assign lane_n[0] = l_byte_lane_n;
  assign lane_n[1] = r_byte_lane_n;
  assign wdata[0] = l_data_in;
  assign wdata[1] = r_data_in;
  assign rdata[0] = l_array_rdata;
  assign rdata[1] = r_array_rdata;
  assign array_rd = {r_array_read_reg, l_array_read_reg};

  // ********************************************************
  // Port logic
  // ********************************************************
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      // The strobe picks the pin address; otherwise the counter addresses the access.
      assign access_addr[p] = !strobe_n[p] ? addr_in[p] : counter_q[p];
      assign access[p] = port_selected(cs_low[p], cs_high[p]) && mask_sel_n[p];
      assign lane_any[p] = lane_n[p] != dprpc_pkg::LANE_IDLE;
      assign is_write[p] = access[p] && !rw_n[p];
      assign is_read[p] = access[p] && rw_n[p];
      assign mbox_set[p] = is_write[1-p] && lane_any[1-p] && (access_addr[1-p] == mbox_of(p));
      assign mbox_clear[p] = is_read[p] && lane_any[p] && (access_addr[p] == mbox_of(p));

      dprpc_port_counter u_counter (
        .sys_clk(sys_clk),
        .reset_all_n(reset_all_n),
        .address_inputs(addr_in[p]),
        .address_strobe_n(strobe_n[p]),
        .count_advance_n(advance_n[p]),
        .counter_clear_n(clear_n[p]),
        .mask_select_n(mask_sel_n[p]),
        .counter_reg(counter_q[p]),
        .mask_reg(),
        .counter_wrap_flag_n(wrap_flag_n[p])
      );

      dprpc_mailbox_flag u_mailbox (
        .sys_clk(sys_clk),
        .reset_all_n(reset_all_n),
        .set_evt(mbox_set[p]),
        .clear_evt(mbox_clear[p]),
        .mailbox_flag_n(mbox_flag_n[p])
      );

      // Read data is held in a register so the pins never see the raw array path.
      always_ff @(posedge sys_clk or negedge reset_all_n)
      begin
        if (!reset_all_n)
        begin
          dout_reg[p] <= dprpc_pkg::DATA_RESET;
          dvalid_reg[p] <= 1'b0;
        end
        else
        begin
          dvalid_reg[p] <= array_rd[p];
          if (array_rd[p])
            dout_reg[p] <= rdata[p];
        end
      end

      property p_mbox_needs_lane;
        @(posedge sys_clk) disable iff (!reset_all_n)
        ($fell(mbox_flag_n[p])) |-> $past(is_write[1-p] && lane_any[1-p]);
      endproperty
      a_mbox_needs_lane: assert property (p_mbox_needs_lane) else $error("mailbox set without active lane");

      property p_idle_flag_holds;
        @(posedge sys_clk) disable iff (!reset_all_n)
        (!mbox_set[p] && !mbox_clear[p]) |=> $stable(mbox_flag_n[p]);
      endproperty
      a_idle_flag_holds: assert property (p_idle_flag_holds) else $error("mailbox flag moved on its own");
    end
  endgenerate

  // ********************************************************
  // Array access register
  // ********************************************************
  // A write with no active lane is still issued; the array ignores it per lane.
  always_ff @(posedge sys_clk or negedge reset_all_n)
  begin
    if (!reset_all_n)
    begin
      l_array_addr_reg <= dprpc_pkg::CNT_RESET;
      l_array_write_reg <= 1'b0;
      l_array_read_reg <= 1'b0;
      l_array_lane_en_reg <= ~dprpc_pkg::LANE_IDLE;
      l_array_wdata_reg <= dprpc_pkg::DATA_RESET;
    end
    else
    begin
      l_array_addr_reg <= access_addr[0];
      l_array_write_reg <= is_write[0];
      l_array_read_reg <= is_read[0];
      l_array_lane_en_reg <= ~lane_n[0];
      l_array_wdata_reg <= wdata[0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_all_n)
  begin
    if (!reset_all_n)
    begin
      r_array_addr_reg <= dprpc_pkg::CNT_RESET;
      r_array_write_reg <= 1'b0;
      r_array_read_reg <= 1'b0;
      r_array_lane_en_reg <= ~dprpc_pkg::LANE_IDLE;
      r_array_wdata_reg <= dprpc_pkg::DATA_RESET;
    end
    else
    begin
      r_array_addr_reg <= access_addr[1];
      r_array_write_reg <= is_write[1];
      r_array_read_reg <= is_read[1];
      r_array_lane_en_reg <= ~lane_n[1];
      r_array_wdata_reg <= wdata[1];
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  // Output enable is a pure gate with no register, so it acts between clock edges.
  assign l_data_oe = dvalid_reg[0] && !oe_n[0];
  assign r_data_oe = dvalid_reg[1] && !oe_n[1];
  assign l_data_out = dout_reg[0];
  assign r_data_out = dout_reg[1];
  assign l_mailbox_flag_n = mbox_flag_n[0];
  assign r_mailbox_flag_n = mbox_flag_n[1];
  assign l_counter_wrap_flag_n = wrap_flag_n[0];
  assign r_counter_wrap_flag_n = wrap_flag_n[1];

  property p_oe_gate;
    @(posedge sys_clk) disable iff (!reset_all_n)
    l_data_oe |-> (!l_output_enable_n && $past(l_array_read_reg));
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("left data driven without enable");

  property p_read_to_oe;
    @(posedge sys_clk) disable iff (!reset_all_n)
    is_read[1] ##2 !r_output_enable_n |-> r_data_oe;
  endproperty
  a_read_to_oe: assert property (p_read_to_oe) else $error("right read data not driven");

  property p_deselect_no_write;
    @(posedge sys_clk) disable iff (!reset_all_n)
    (l_chip_select_low_active || !l_chip_select_high_active) |=> !l_array_write_reg;
  endproperty
  a_deselect_no_write: assert property (p_deselect_no_write) else $error("write while deselected");

  property p_right_mbox_set;
    @(posedge sys_clk) disable iff (!reset_all_n)
    (is_write[0] && lane_any[0] && access_addr[0] == dprpc_pkg::MBOX_RIGHT_ADDR) |=> !r_mailbox_flag_n;
  endproperty
  a_right_mbox_set: assert property (p_right_mbox_set) else $error("right mailbox flag not set");

  property p_own_write_no_set;
    @(posedge sys_clk) disable iff (!reset_all_n)
    (l_mailbox_flag_n && !is_write[1]) |=> l_mailbox_flag_n;
  endproperty
  a_own_write_no_set: assert property (p_own_write_no_set) else $error("left flag set by own port");

endmodule : dprpc_top

`default_nettype wire

// ---- shared/dprpc_pkg.sv ----
// Constants shared by the port control logic of the dual-port RAM.
// Assumes a single system clock for both ports and an 18-bit address space.
package dprpc_pkg;

  // ********************************************************
  // Widths and port indices
  // ********************************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int LANE_W = 4;
  localparam int PORT_LEFT = 0;
  localparam int PORT_RIGHT = 1;

  // ********************************************************
  // Mailbox locations and reset values
  // ********************************************************
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 18'h3FFFF;
  localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR = 18'h3FFFE;
  localparam logic [ADDR_W-1:0] CNT_RESET = 18'h00000;
  localparam logic [ADDR_W-1:0] MASK_RESET = 18'h3FFFF;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;
  localparam logic [LANE_W-1:0] LANE_IDLE = 4'hF;
  localparam logic FLAG_IDLE = 1'b1;

endpackage : dprpc_pkg

// ---- rtl/dprpc_port_counter.sv ----
// Burst address counter and counter mask register of one port.
// Assumes the caller combines system reset and master clear into reset_all_n.
`timescale 1ns/10ps
`default_nettype none

module dprpc_port_counter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_all_n,
  // Counter control
  input wire logic [dprpc_pkg::ADDR_W-1:0] address_inputs,
  input wire logic address_strobe_n,
  input wire logic count_advance_n,
  input wire logic counter_clear_n,
  input wire logic mask_select_n,
  // State
  output logic [dprpc_pkg::ADDR_W-1:0] counter_reg,
  output logic [dprpc_pkg::ADDR_W-1:0] mask_reg,
  output logic counter_wrap_flag_n
);

  // Masked bits hold; the unmasked bits count as one field.
  function automatic logic [dprpc_pkg::ADDR_W-1:0] masked_incr(
    input logic [dprpc_pkg::ADDR_W-1:0] cnt,
    input logic [dprpc_pkg::ADDR_W-1:0] mask
  );
    logic [dprpc_pkg::ADDR_W-1:0] sum;
    sum = (cnt | ~mask) + 18'h00001;
    return (cnt & ~mask) | (sum & mask);
  endfunction : masked_incr

  logic [dprpc_pkg::ADDR_W-1:0] counter_next;
  logic do_incr;

  assign counter_next = masked_incr(counter_reg, mask_reg);
  assign do_incr = mask_select_n && counter_clear_n && address_strobe_n && !count_advance_n;

  // ********************************************************
  // Counter
  // ********************************************************
  always_ff @(posedge sys_clk or negedge reset_all_n)
  begin
    if (!reset_all_n)
      counter_reg <= dprpc_pkg::CNT_RESET;
    else if (mask_select_n)
    begin
      if (!counter_clear_n)
        counter_reg <= counter_reg & ~mask_reg;
      else if (!address_strobe_n)
        counter_reg <= address_inputs;
      else if (do_incr)
        counter_reg <= counter_next;
    end
  end

  // ********************************************************
  // Mask register
  // ********************************************************
  always_ff @(posedge sys_clk or negedge reset_all_n)
  begin
    if (!reset_all_n)
      mask_reg <= dprpc_pkg::MASK_RESET;
    else if (!mask_select_n)
    begin
      if (!counter_clear_n)
        mask_reg <= dprpc_pkg::MASK_RESET;
      else if (!address_strobe_n)
        mask_reg <= address_inputs;
    end
  end

  // ********************************************************
  // Wrap flag
  // ********************************************************
  // A fresh load or clear restarts the count, so it also withdraws the flag.
  always_ff @(posedge sys_clk or negedge reset_all_n)
  begin
    if (!reset_all_n)
      counter_wrap_flag_n <= dprpc_pkg::FLAG_IDLE;
    else if (do_incr && ((counter_next & mask_reg) == mask_reg))
      counter_wrap_flag_n <= 1'b0;
    else if (mask_select_n && (!counter_clear_n || !address_strobe_n))
      counter_wrap_flag_n <= 1'b1;
  end

  property p_clear_zeroes_unmasked;
    @(posedge sys_clk) disable iff (!reset_all_n)
    (mask_select_n && !counter_clear_n) |=> ((counter_reg & mask_reg) == 18'h00000);
  endproperty
  a_clear_zeroes_unmasked: assert property (p_clear_zeroes_unmasked) else $error("clear left unmasked bits set");

  property p_clear_keeps_masked;
    @(posedge sys_clk) disable iff (!reset_all_n)
    (mask_select_n && !counter_clear_n) |=> ((counter_reg & ~mask_reg) == ($past(counter_reg) & ~mask_reg));
  endproperty
  a_clear_keeps_masked: assert property (p_clear_keeps_masked) else $error("clear changed masked bits");

  property p_load;
    @(posedge sys_clk) disable iff (!reset_all_n)
    (mask_select_n && counter_clear_n && !address_strobe_n) |=> (counter_reg == $past(address_inputs));
  endproperty
  a_load: assert property (p_load) else $error("strobe did not load counter");

  property p_incr;
    @(posedge sys_clk) disable iff (!reset_all_n)
    (do_incr && mask_reg == 18'h3FFFF) |=> (counter_reg == $past(counter_reg) + 18'h00001);
  endproperty
  a_incr: assert property (p_incr) else $error("counter did not advance");

  property p_hold;
    @(posedge sys_clk) disable iff (!reset_all_n)
    (mask_select_n && counter_clear_n && address_strobe_n && count_advance_n) |=> $stable(counter_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without advance");

  property p_mask_untouched;
    @(posedge sys_clk) disable iff (!reset_all_n)
    mask_select_n |=> $stable(mask_reg);
  endproperty
  a_mask_untouched: assert property (p_mask_untouched) else $error("mask changed while not selected");

  property p_wrap;
    @(posedge sys_clk) disable iff (!reset_all_n)
    (do_incr && ((counter_next & mask_reg) == mask_reg)) |=> !counter_wrap_flag_n;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag missed");

endmodule : dprpc_port_counter

`default_nettype wire

// ---- rtl/dprpc_mailbox_flag.sv ----
// Active-low mailbox flag of one port; a set beats a clear in the same cycle.
// Assumes set and clear events are single-cycle qualified strobes.
`timescale 1ns/10ps
`default_nettype none

module dprpc_mailbox_flag (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_all_n,
  // Events
  input wire logic set_evt,
  input wire logic clear_evt,
  // Flag
  output logic mailbox_flag_n
);

  always_ff @(posedge sys_clk or negedge reset_all_n)
  begin
    if (!reset_all_n)
      mailbox_flag_n <= dprpc_pkg::FLAG_IDLE;
    else if (set_evt)
      mailbox_flag_n <= 1'b0;
    else if (clear_evt)
      mailbox_flag_n <= 1'b1;
  end

  property p_set;
    @(posedge sys_clk) disable iff (!reset_all_n)
    set_evt |=> !mailbox_flag_n;
  endproperty
  a_set: assert property (p_set) else $error("mailbox flag not set");

  property p_clear;
    @(posedge sys_clk) disable iff (!reset_all_n)
    (clear_evt && !set_evt) |=> mailbox_flag_n;
  endproperty
  a_clear: assert property (p_clear) else $error("mailbox flag not cleared");

endmodule : dprpc_mailbox_flag

`default_nettype wire

// ---- testbench/dprpc_array_model.sv ----
// Shared memory array model standing behind both ports of the port control block.
// Assumes registered array commands and read data due in the cycle of the read strobe.
`timescale 1ns/10ps
`default_nettype none

module dprpc_array_model (
  // Clock
  input wire logic sys_clk,
  // Left port
  input wire logic [17:0] l_addr,
  input wire logic l_wr,
  input wire logic l_rd,
  input wire logic [3:0] l_lane,
  input wire logic [35:0] l_wdata,
  output logic [35:0] l_rdata,
  // Right port
  input wire logic [17:0] r_addr,
  input wire logic r_wr,
  input wire logic r_rd,
  input wire logic [3:0] r_lane,
  input wire logic [35:0] r_wdata,
  output logic [35:0] r_rdata
);
  logic [35:0] mem [0:262143];
  logic [35:0] junk = 36'h5A5A5A5A5;

  // Outside a read the data changes every cycle, so a stale value never passes for read data.
  assign l_rdata = l_rd ? mem[l_addr] : junk;
  assign r_rdata = r_rd ? mem[r_addr] : ~junk;

  always @(posedge sys_clk)
  begin
    junk <= ~junk;
    for (int i = 0; i < 4; i++)
    begin
      if (l_wr && l_lane[i])
        mem[l_addr][i*9 +: 9] <= l_wdata[i*9 +: 9];
      if (r_wr && r_lane[i])
        mem[r_addr][i*9 +: 9] <= r_wdata[i*9 +: 9];
    end
  end
endmodule : dprpc_array_model
`default_nettype wire

// ---- testbench/dprpc_top_tb.sv ----
// Self-checking bench for the dual-port RAM port control block.
// Assumes the shared array model and inputs driven on the falling clock edge.
`timescale 1ns/10ps
`default_nettype none

module dprpc_top_tb;
  // ********************************************************
  // Stimulus and observed signals
  // ********************************************************
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic mclr_n = 1'b1;
  logic [17:0] l_a = 18'h00000, r_a = 18'h00000, l_aa, r_aa;
  logic l_s = 1'b1, r_s = 1'b1, l_cl = 1'b1, r_cl = 1'b1, l_ch = 1'b0, r_ch = 1'b0;
  logic l_adv = 1'b1, r_adv = 1'b1, l_clr = 1'b1, r_clr = 1'b1, l_m = 1'b1, r_m = 1'b1;
  logic l_rw = 1'b1, r_rw = 1'b1, l_oe = 1'b0, r_oe = 1'b0;
  logic [3:0] l_ln = 4'hF, r_ln = 4'hF, l_al, r_al;
  logic [35:0] l_d = 36'h000000000, r_d = 36'h000000000, l_do, r_do, l_awd, r_awd, l_ard, r_ard;
  logic l_doe, r_doe, l_mf, r_mf, l_wf, r_wf, l_aw, r_aw, l_ar, r_ar;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  dprpc_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .master_clear_n(mclr_n),
    .l_address_inputs(l_a), .l_address_strobe_n(l_s), .l_chip_select_low_active(l_cl),
    .l_chip_select_high_active(l_ch), .l_count_advance_n(l_adv), .l_counter_clear_n(l_clr),
    .l_mask_select_n(l_m), .l_read_write_n(l_rw), .l_byte_lane_n(l_ln), .l_output_enable_n(l_oe),
    .l_data_in(l_d), .l_data_out(l_do), .l_data_oe(l_doe), .l_mailbox_flag_n(l_mf),
    .l_counter_wrap_flag_n(l_wf), .r_address_inputs(r_a), .r_address_strobe_n(r_s),
    .r_chip_select_low_active(r_cl), .r_chip_select_high_active(r_ch), .r_count_advance_n(r_adv),
    .r_counter_clear_n(r_clr), .r_mask_select_n(r_m), .r_read_write_n(r_rw), .r_byte_lane_n(r_ln),
    .r_output_enable_n(r_oe), .r_data_in(r_d), .r_data_out(r_do), .r_data_oe(r_doe),
    .r_mailbox_flag_n(r_mf), .r_counter_wrap_flag_n(r_wf), .l_array_addr_reg(l_aa),
    .l_array_write_reg(l_aw), .l_array_read_reg(l_ar), .l_array_lane_en_reg(l_al),
    .l_array_wdata_reg(l_awd), .l_array_rdata(l_ard), .r_array_addr_reg(r_aa),
    .r_array_write_reg(r_aw), .r_array_read_reg(r_ar), .r_array_lane_en_reg(r_al),
    .r_array_wdata_reg(r_awd), .r_array_rdata(r_ard));

  dprpc_array_model model (.sys_clk(sys_clk), .l_addr(l_aa), .l_wr(l_aw), .l_rd(l_ar), .l_lane(l_al),
    .l_wdata(l_awd), .l_rdata(l_ard), .r_addr(r_aa), .r_wr(r_aw), .r_rd(r_ar), .r_lane(r_al),
    .r_wdata(r_awd), .r_rdata(r_ard));

  always #20 sys_clk = ~sys_clk;

  // The whole run needs well under a hundred cycles.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      close_out();
    end
  end

  // ********************************************************
  // Shared tasks
  // ********************************************************
  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // One left-port cycle of counter controls; a selected cycle is a read.
  task automatic lp(input logic [17:0] a, input logic s, adv, clr, m, cl, ch);
    l_a = a;
    l_s = s;
    l_adv = adv;
    l_clr = clr;
    l_m = m;
    l_cl = cl;
    l_ch = ch;
    l_rw = 1'b1;
    @(negedge sys_clk);
  endtask : lp

  // One strobed access by port p (0 left, 1 right); the other port stays deselected.
  // The port is left selected on return, so back-to-back calls drive each pin once per step.
  task automatic acc(input bit p, input logic [17:0] a, input logic rw, input logic [3:0] ln,
                     input logic [35:0] d);
    l_a = a;
    r_a = a;
    l_rw = rw;
    r_rw = rw;
    l_ln = ln;
    r_ln = ln;
    l_d = d;
    r_d = d;
    l_s = 1'b0;
    r_s = 1'b0;
    l_adv = 1'b1;
    l_clr = 1'b1;
    l_m = 1'b1;
    l_ch = 1'b1;
    r_ch = 1'b1;
    l_cl = p;
    r_cl = !p;
    @(negedge sys_clk);
  endtask : acc

  // Deselects both ports and lifts both strobes without waiting for an edge.
  task automatic idle();
    l_cl = 1'b1;
    r_cl = 1'b1;
    l_s = 1'b1;
    r_s = 1'b1;
  endtask : idle

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_counter();
    chk("reset flags", 36'hF, {l_mf, r_mf, l_wf, r_wf});
    lp(18'h0000F, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    lp(18'h0002D, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    lp(18'h00000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    chk("addr load", 36'h2D, l_aa);
    chk("wrap early", 36'h1, l_wf);
    lp(18'h00000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    chk("wrap", 36'h0, l_wf);
    lp(18'h00000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    lp(18'h00000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    chk("addr wrapped", 36'h20, l_aa);
    lp(18'h0004B, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    lp(18'h00000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    chk("addr no inc", 36'h4B, l_aa);
    lp(18'h3FFF0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    lp(18'h00000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    chk("mask cycle read", 36'h0, l_ar);
    lp(18'h00000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    chk("addr clear", 36'h40, l_aa);
    $display("test counter done");
  endtask : t_counter

  task automatic t_cs();
    for (int i = 0; i < 4; i++)
    begin
      lp(18'h00055, 1'b0, 1'b1, 1'b1, 1'b1, i[0], i[1]);
      chk("select", {35'h0, i == 2}, l_ar);
    end
    $display("test chip select done");
  endtask : t_cs

  task automatic t_mbox();
    acc(1'b0, 18'h3FFFF, 1'b0, 4'hF, 36'h0);
    chk("no lane set", 36'h1, r_mf);
    acc(1'b0, 18'h3FFFF, 1'b0, 4'hE, 36'h0);
    chk("right set", 36'h0, r_mf);
    acc(1'b0, 18'h3FFFE, 1'b0, 4'h0, 36'h0);
    chk("own write", 36'h1, l_mf);
    acc(1'b0, 18'h3FFFF, 1'b1, 4'h0, 36'h0);
    acc(1'b1, 18'h3FFFF, 1'b1, 4'hF, 36'h0);
    chk("no lane clear", 36'h0, r_mf);
    acc(1'b1, 18'h3FFFF, 1'b1, 4'h7, 36'h0);
    chk("right clear", 36'h1, r_mf);
    acc(1'b1, 18'h3FFFE, 1'b0, 4'h0, 36'h0);
    chk("left set", 36'h0, l_mf);
    idle();
    mclr_n = 1'b0;
    @(negedge sys_clk);
    chk("master clear", 36'h1, l_mf);
    mclr_n = 1'b1;
    lp(18'h00000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    chk("addr cleared", 36'h0, l_aa);
    $display("test mailbox done");
  endtask : t_mbox

  task automatic t_oe();
    acc(1'b0, 18'h00100, 1'b0, 4'h0, 36'h9ABCDEF01);
    chk("write strobe", 36'h1, l_aw);
    chk("write lanes", 36'hF, l_al);
    chk("write data", 36'h9ABCDEF01, l_awd);
    acc(1'b1, 18'h00100, 1'b1, 4'h0, 36'h0);
    idle();
    @(negedge sys_clk);
    chk("read data", 36'h9ABCDEF01, r_do);
    chk("drive", 36'h1, r_doe);
    r_oe = 1'b1;
    #1;
    chk("drive off", 36'h0, r_doe);
    r_oe = 1'b0;
    @(negedge sys_clk);
    chk("drive idle", 36'h0, r_doe);
    acc(1'b0, 18'h00100, 1'b1, 4'h0, 36'h0);
    idle();
    @(negedge sys_clk);
    chk("left read data", 36'h9ABCDEF01, l_do);
    chk("left drive", 36'h1, l_doe);
    $display("test output enable done");
  endtask : t_oe

  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst_b = 1'b1;
    t_counter();
    t_cs();
    t_mbox();
    t_oe();
    close_out();
  end
endmodule : dprpc_top_tb
`default_nettype wire
